// ==== design/ndw_ctrl.sv ====
// Implementation choice: the Avalon-MM slave port.
`timescale 1ns/100ps
// Contract
// - with write mode off, array reads like ROM, data within one clock
// - write mode on, program idle: each array write lands in one of 16 latches
// - program start writes all latched bytes into row of last array write
// - cycle end clears program flag and write mode together, irq if enabled
// - pending irq drops when the cpu fetches its vector
// - latches clear at cycle end or write-mode fall; rewrites AND together
// - latched data can never be read back
// - wait request: enter wait at once if idle, else after the cycle
// - halt request stops at once, abandoning any cycle
// - array read in write mode leaves data undriven (here the array is not read and the data reads as zero)
// - array write with write mode off is ignored
// - cycle cut by reset or software clear leaves cells undefined
// - control register resets to zero, bits 7:3 read zero
// - bit 2 enables the completion interrupt
// - bit 1 write mode; software clear only while program flag clear
// - bit 0 program flag: write 1 starts, reads 1 while running
module ndw_ctrl
  import ndw_pkg::*;
#(
  parameter int EE_AW = EE_ADDR_W,
  parameter int PROG_CYC = PROG_CYCLES
) (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic [11:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  input wire logic sleep_wait_instr_i,
  input wire logic halt_req_i,
  input wire logic vector_fetch_i,
  output logic irq_o,
  output logic wait_state_o,
  output logic halted_o
);

  localparam int CNT_W = $clog2(PROG_CYC + 1);
  localparam logic [LATCH_IW-1:0] LAST_IDX = LATCH_IW'(LATCH_N - 1);

  // ----------------------------------------------------------------
  // bus slave: every access takes exactly one wait cycle
  // ----------------------------------------------------------------
  logic ack_reg;
  logic req;
  logic csr_hit;
  logic ee_hit;
  logic wr_acc;
  logic csr_wr;
  logic ee_wr;
  logic rd_issue;
  logic [7:0] wd;
  logic [EE_AW-1:0] bus_idx;

  assign req = avs_read_i | avs_write_i;
  assign avs_waitrequest_o = req & ~ack_reg;
  assign csr_hit = (avs_address_i == CSR_OFF);
  assign ee_hit = (avs_address_i[11:10] == EE_SEL);
  assign bus_idx = avs_address_i[EE_AW+1:2];
  assign wr_acc = avs_write_i & ack_reg & avs_byteenable_i[0];
  assign csr_wr = wr_acc & csr_hit;
  assign ee_wr = wr_acc & ee_hit;
  assign wd = avs_writedata_i[7:0];

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= req & ~ack_reg;
    end
  end

  // ----------------------------------------------------------------
  // control/status bits
  // ----------------------------------------------------------------
  ndw_state_t state_reg;
  logic [CNT_W-1:0] cnt_reg;
  logic [LATCH_IW-1:0] cidx_reg;
  logic pgm_reg;
  logic lat_reg;
  logic ie_reg;
  logic lat_d_reg;
  logic start;
  logic sw_abort;
  logic commit_done;

  assign commit_done = (state_reg == NDW_COMMIT) && (cidx_reg == LAST_IDX);
  assign start = csr_wr & wd[BIT_PGM] & ~pgm_reg & (lat_reg | wd[BIT_LAT]) & ~halt_req_i;
  assign sw_abort = csr_wr & ~wd[BIT_PGM] & pgm_reg;

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      ie_reg <= CSR_RESET[BIT_IE];
    end else if (csr_wr) begin
      ie_reg <= wd[BIT_IE];
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      lat_reg <= CSR_RESET[BIT_LAT];
    end else if (commit_done) begin
      lat_reg <= 1'b0;
    end else if (csr_wr && wd[BIT_LAT]) begin
      lat_reg <= 1'b1;
    end else if (csr_wr && !pgm_reg) begin
      lat_reg <= 1'b0;
    end
  end

  // a software clear mid-cycle aborts; cell contents are then undefined
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      pgm_reg <= CSR_RESET[BIT_PGM];
    end else if (commit_done || halt_req_i) begin
      pgm_reg <= 1'b0;
    end else if (start) begin
      pgm_reg <= 1'b1;
    end else if (sw_abort) begin
      pgm_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      lat_d_reg <= 1'b0;
    end else begin
      lat_d_reg <= lat_reg;
    end
  end

  // ----------------------------------------------------------------
  // programming sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (reset_i || halt_req_i || sw_abort) begin
      state_reg <= NDW_IDLE;
      cnt_reg <= '0;
      cidx_reg <= '0;
    end else begin
      unique case (state_reg)
        NDW_IDLE: begin
          if (start) begin
            state_reg <= NDW_PROG;
            cnt_reg <= '0;
          end
        end
        NDW_PROG: begin
          if (cnt_reg == CNT_W'(PROG_CYC - 1)) begin
            state_reg <= NDW_COMMIT;
            cidx_reg <= '0;
          end else begin
            cnt_reg <= cnt_reg + 1'b1;
          end
        end
        NDW_COMMIT: begin
          if (cidx_reg == LAST_IDX) begin
            state_reg <= NDW_IDLE;
          end else begin
            cidx_reg <= cidx_reg + 1'b1;
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // latches and row address
  // ----------------------------------------------------------------
  logic [EE_AW-LATCH_IW-1:0] row_reg;
  logic latch_wr;
  logic latch_clr;
  logic [7:0] sel_data;
  logic sel_valid;

  // writes with write mode off, or while programming, are dropped
  assign latch_wr = ee_wr & lat_reg & ~pgm_reg;
  assign latch_clr = commit_done | (lat_d_reg & ~lat_reg);

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      row_reg <= '0;
    end else if (latch_wr) begin
      row_reg <= bus_idx[EE_AW-1:LATCH_IW];
    end
  end

  ndw_latch #(
    .N(LATCH_N),
    .IW(LATCH_IW)
  ) u_latch (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .wr_i(latch_wr),
    .wr_idx_i(bus_idx[LATCH_IW-1:0]),
    .wr_data_i(wd),
    .clr_i(latch_clr),
    .sel_idx_i(cidx_reg),
    .sel_data_o(sel_data),
    .sel_valid_o(sel_valid)
  );

  // ----------------------------------------------------------------
  // cell array port
  // ----------------------------------------------------------------
  ndw_mem_if #(.AW(EE_AW)) mif ();
  logic commit_we;

  assign commit_we = (state_reg == NDW_COMMIT) & sel_valid & ~halt_req_i;
  assign rd_issue = avs_read_i & ~ack_reg & ee_hit & ~lat_reg;
  assign mif.en = commit_we | rd_issue;
  assign mif.we = commit_we;
  assign mif.addr = commit_we ? {row_reg, cidx_reg} : bus_idx;
  assign mif.wdata = sel_data;

  ndw_mem #(
    .AW(EE_AW)
  ) u_mem (
    .clk_i(clk_i),
    .port_if(mif)
  );

  // ----------------------------------------------------------------
  // read data
  // ----------------------------------------------------------------
  logic rd_ee_reg;
  logic [7:0] rd_val_reg;

  // array reads in write mode return zero: the array is not read and the byte lane is driven with 8'h00
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      rd_ee_reg <= 1'b0;
      rd_val_reg <= 8'h00;
    end else if (avs_read_i && !ack_reg) begin
      rd_ee_reg <= rd_issue;
      rd_val_reg <= csr_hit ? {5'h00, ie_reg, lat_reg, pgm_reg} : 8'h00;
    end
  end

  assign avs_readdata_o = {24'h00_0000, rd_ee_reg ? mif.rdata : rd_val_reg};

  // ----------------------------------------------------------------
  // interrupt, wait and halt
  // ----------------------------------------------------------------
  logic irq_reg;
  logic wait_reg;
  logic halted_reg;

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      irq_reg <= 1'b0;
    end else if (commit_done && ie_reg) begin
      irq_reg <= 1'b1;
    end else if (vector_fetch_i) begin
      irq_reg <= 1'b0;
    end
  end

  // a running cycle holds off wait entry until the sequencer is idle again
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      wait_reg <= 1'b0;
    end else begin
      wait_reg <= sleep_wait_instr_i & (state_reg == NDW_IDLE);
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      halted_reg <= 1'b0;
    end else begin
      halted_reg <= halt_req_i;
    end
  end

  assign irq_o = irq_reg;
  assign wait_state_o = wait_reg;
  assign halted_o = halted_reg;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);

  // the timing phase can outlast any plain delay, so its length is counted here
  logic [CNT_W-1:0] plen_reg;

  always_ff @(posedge clk_i) begin
    if (reset_i || state_reg != NDW_PROG) begin
      plen_reg <= '0;
    end else begin
      plen_reg <= plen_reg + 1'b1;
    end
  end

  a_read_latency: assert property ((avs_read_i && avs_waitrequest_o) |=> !avs_waitrequest_o)
    else $error("read not answered after one wait cycle");
  a_latch_store: assert property ((ee_wr && lat_reg && !pgm_reg) |-> latch_wr)
    else $error("array write in write mode not latched");
  a_ignored_write: assert property ((ee_wr && !lat_reg) |-> !latch_wr)
    else $error("array write latched with write mode off");
  a_cell_write: assert property (mif.we |-> (state_reg == NDW_COMMIT) && pgm_reg)
    else $error("cell written outside a commit");
  a_end_clears: assert property (commit_done |=> !pgm_reg && !lat_reg && state_reg == NDW_IDLE)
    else $error("cycle end did not clear program flag and write mode");
  a_irq_raise: assert property ((commit_done && ie_reg) |=> irq_o)
    else $error("completion interrupt missing");
  a_irq_drop: assert property ((vector_fetch_i && !commit_done) |=> !irq_o)
    else $error("interrupt kept after vector fetch");
  a_lat_hold: assert property ((csr_wr && !wd[BIT_LAT] && pgm_reg && !commit_done) |=> lat_reg)
    else $error("write mode cleared while programming");
  a_prog_flag: assert property ((state_reg != NDW_IDLE) |-> pgm_reg)
    else $error("program flag low during a cycle");
  a_prog_length: assert property ($rose(state_reg == NDW_COMMIT) |-> plen_reg == CNT_W'(PROG_CYC))
    else $error("programming time wrong");
  a_lat_read_zero: assert property ((avs_read_i && avs_waitrequest_o && ee_hit && lat_reg)
    |=> avs_readdata_o == 32'h0000_0000)
    else $error("array read in write mode returned data");
  a_reserved_zero: assert property ((avs_read_i && avs_waitrequest_o && csr_hit)
    |=> avs_readdata_o[31:3] == 29'h0000_0000)
    else $error("reserved bits read nonzero");
  a_halt_stop: assert property (halt_req_i |=> state_reg == NDW_IDLE && !pgm_reg)
    else $error("halt did not abandon the cycle");
  a_wait_idle: assert property ((sleep_wait_instr_i && state_reg == NDW_IDLE) |=> wait_state_o)
    else $error("wait not entered while idle");

  c_commit: cover property (commit_done && ie_reg);
  c_ee_read: cover property (avs_read_i && !avs_waitrequest_o && rd_ee_reg);
  c_halt_abort: cover property (halt_req_i && state_reg == NDW_PROG);
  c_wait_after: cover property (sleep_wait_instr_i && commit_done);

endmodule : ndw_ctrl

// ==== design/ndw_latch.sv ====
`timescale 1ns/100ps
module ndw_latch #(
  parameter int N = 16,
  parameter int IW = 4
) (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic wr_i,
  input wire logic [IW-1:0] wr_idx_i,
  input wire logic [7:0] wr_data_i,
  input wire logic clr_i,
  input wire logic [IW-1:0] sel_idx_i,
  output logic [7:0] sel_data_o,
  output logic sel_valid_o
);

  // ----------------------------------------------------------------
  // row latches
  // ----------------------------------------------------------------
  logic [7:0] data_reg [N];
  logic [N-1:0] valid_reg;

  // a second write to a filled latch over-programs: the bits are ANDed
  always_ff @(posedge clk_i) begin
    if (reset_i || clr_i) begin
      valid_reg <= '0;
    end else if (wr_i) begin
      valid_reg[wr_idx_i] <= 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (wr_i && !clr_i) begin
      data_reg[wr_idx_i] <= valid_reg[wr_idx_i] ? (data_reg[wr_idx_i] & wr_data_i)
                                                : wr_data_i;
    end
  end

  // only the commit sequencer looks here; no bus path exists
  assign sel_data_o = data_reg[sel_idx_i];
  assign sel_valid_o = valid_reg[sel_idx_i];

endmodule : ndw_latch

// ==== design/ndw_mem.sv ====
`timescale 1ns/100ps
module ndw_mem #(
  parameter int AW = 8
) (
  input wire logic clk_i,
  ndw_mem_if.mem port_if
);

  // ----------------------------------------------------------------
  // cell array, registered read
  // ----------------------------------------------------------------
  logic [7:0] cells [2**AW];
  logic [7:0] rdata_reg;

  always_ff @(posedge clk_i) begin
    if (port_if.en) begin
      if (port_if.we) begin
        cells[port_if.addr] <= port_if.wdata;
      end else begin
        rdata_reg <= cells[port_if.addr];
      end
    end
  end

  assign port_if.rdata = rdata_reg;

endmodule : ndw_mem

// ==== inc/ndw_mem_if.sv ====
`timescale 1ns/100ps
interface ndw_mem_if #(
  parameter int AW = 8
);
  logic en;
  logic we;
  logic [AW-1:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;

  modport ctrl (output en, output we, output addr, output wdata, input rdata);
  modport mem (input en, input we, input addr, input wdata, output rdata);
endinterface : ndw_mem_if

// ==== inc/ndw_pkg.sv ====
package ndw_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [11:0] CSR_OFF = 12'h002C;
  localparam logic [1:0] EE_SEL = 2'h1;
  localparam logic [7:0] CSR_RESET = 8'h00;
  localparam int BIT_PGM = 0;
  localparam int BIT_LAT = 1;
  localparam int BIT_IE = 2;

  // ----------------------------------------------------------------
  // array shape
  // ----------------------------------------------------------------
  localparam int EE_ADDR_W = 8;
  localparam int LATCH_N = 16;
  localparam int LATCH_IW = 4;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int PROG_TIME_NS = 5000;
  localparam int PROG_CYCLES = PROG_TIME_NS / CLK_PERIOD_NS;

  typedef enum logic [1:0] {
    NDW_IDLE,
    NDW_PROG,
    NDW_COMMIT
  } ndw_state_t;

endpackage : ndw_pkg

// ==== sim/ndw_cpu_model.sv ====
`timescale 1ns/100ps
// ----------------------------------------------------------------
// cpu side of the register bus: one data access at a time
// ----------------------------------------------------------------
module ndw_cpu_model (
  input wire logic clk_i,
  output logic [11:0] avs_address_o,
  output logic avs_read_o,
  output logic avs_write_o,
  output logic [31:0] avs_writedata_o,
  output logic [3:0] avs_byteenable_o,
  input wire logic [31:0] avs_readdata_i,
  input wire logic avs_waitrequest_i
);
  initial begin
    avs_address_o = 12'h000;
    avs_read_o = 1'b0;
    avs_write_o = 1'b0;
    avs_writedata_o = 32'h0000_0000;
    avs_byteenable_o = 4'h0;
  end

  // data reads and writes only; no code is ever fetched from the array
  task automatic xfer(input logic w, input logic [11:0] a, input logic [7:0] d,
      output logic [31:0] q);
    avs_address_o <= a;
    avs_write_o <= w;
    avs_read_o <= ~w;
    avs_writedata_o <= {24'h00_0000, d};
    avs_byteenable_o <= 4'h1;
    @(posedge clk_i);
    while (avs_waitrequest_i) @(posedge clk_i);
    q = avs_readdata_i;
    avs_read_o <= 1'b0;
    avs_write_o <= 1'b0;
    // released lines must not keep showing the old request
    avs_address_o <= ~a;
    avs_writedata_o <= ~{24'h00_0000, d};
    avs_byteenable_o <= 4'h0;
    @(posedge clk_i);
  endtask : xfer
endmodule : ndw_cpu_model

// ==== sim/ndw_ctrl_tb_top.sv ====
`timescale 1ns/100ps
module ndw_ctrl_tb_top;
  import ndw_pkg::*;
  localparam int PC = 8;
  logic clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic sleep_i = 1'b0;
  logic halt_i = 1'b0;
  logic vf_i = 1'b0;
  logic [11:0] addr;
  logic rd;
  logic wrs;
  logic [31:0] wdata;
  logic [3:0] be;
  logic [31:0] rdata;
  logic wait_req;
  logic irq;
  logic wst;
  logic hlt;
  int mismatches = 0;
  int checked = 0;
  int cycles = 0;

  always #5 clk_i = ~clk_i;

  ndw_cpu_model cpu (.clk_i(clk_i), .avs_address_o(addr), .avs_read_o(rd),
    .avs_write_o(wrs), .avs_writedata_o(wdata), .avs_byteenable_o(be),
    .avs_readdata_i(rdata), .avs_waitrequest_i(wait_req));

  ndw_ctrl #(.PROG_CYC(PC)) dut (.clk_i(clk_i), .reset_i(reset_i), .avs_address_i(addr),
    .avs_read_i(rd), .avs_write_i(wrs), .avs_writedata_i(wdata), .avs_byteenable_i(be),
    .avs_readdata_o(rdata), .avs_waitrequest_o(wait_req), .sleep_wait_instr_i(sleep_i),
    .halt_req_i(halt_i), .vector_fetch_i(vf_i), .irq_o(irq), .wait_state_o(wst),
    .halted_o(hlt));

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task stop_test;
    $display("mismatches %0d checked %0d", mismatches, checked);
    if (mismatches == 0 && checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : stop_test

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    logic [31:0] q;
    cpu.xfer(1'b1, a, d, q);
  endtask : wr

  task automatic rd_chk(input string what, input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] q;
    cpu.xfer(1'b0, a, 8'h00, q);
    chk(what, q, exp);
  endtask : rd_chk

  function automatic logic [11:0] ea(input int i);
    return 12'h400 + 12'(i * 4);
  endfunction : ea

  // poll until the program flag drops; a hang counts as a mismatch
  task automatic wait_done();
    logic [31:0] q;
    int n;
    q = 32'h0000_0001;
    n = 0;
    while (q[0] === 1'b1 && n < 100) begin
      cpu.xfer(1'b0, CSR_OFF, 8'h00, q);
      n++;
    end
    if (q[0] !== 1'b0) chk("prog_done", q, 32'h0000_0000);
  endtask : wait_done

  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask : tick

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_regs();
    rd_chk("csr_reset", CSR_OFF, 32'h0000_0000);
    wr(CSR_OFF, 8'hF8);
    rd_chk("csr_reserved", CSR_OFF, 32'h0000_0000);
    wr(CSR_OFF, 8'h04);
    rd_chk("csr_ie", CSR_OFF, 32'h0000_0004);
    rd_chk("unmapped", 12'h030, 32'h0000_0000);
  endtask : t_regs

  // full row with a repeated write, refused clear, irq and vector fetch
  task automatic t_prog();
    wr(CSR_OFF, 8'h06);
    for (int i = 0; i < LATCH_N; i++) wr(ea(16 + i), 8'hA0 + 8'(i));
    wr(ea(16), 8'h3C);
    rd_chk("latch_hidden", ea(17), 32'h0000_0000);
    wr(CSR_OFF, 8'h07);
    rd_chk("flag_running", CSR_OFF, 32'h0000_0007);
    wr(CSR_OFF, 8'h05);
    rd_chk("mode_kept", CSR_OFF, 32'h0000_0007);
    wait_done();
    rd_chk("csr_after", CSR_OFF, 32'h0000_0004);
    tick(2);
    chk("irq_set", {31'h0, irq}, 32'h0000_0001);
    vf_i <= 1'b1;
    tick(1);
    vf_i <= 1'b0;
    tick(2);
    chk("irq_drop", {31'h0, irq}, 32'h0000_0000);
    rd_chk("cell_and", ea(16), 32'h0000_0020);
    for (int i = 1; i < LATCH_N; i++) rd_chk("cell", ea(16 + i), 8'hA0 + 8'(i));
  endtask : t_prog

  // refused write, then latches lost on a mode fall, irq kept off
  task automatic t_clear();
    wr(ea(17), 8'h00);
    rd_chk("ignored_wr", ea(17), 32'h0000_00A1);
    wr(CSR_OFF, 8'h02);
    wr(ea(18), 8'h00);
    wr(CSR_OFF, 8'h00);
    wr(CSR_OFF, 8'h02);
    wr(ea(19), 8'h55);
    wr(CSR_OFF, 8'h03);
    wait_done();
    rd_chk("latch_cleared", ea(18), 32'h0000_00A2);
    rd_chk("cell_new", ea(19), 32'h0000_0055);
    chk("irq_off", {31'h0, irq}, 32'h0000_0000);
  endtask : t_clear

  task automatic t_wait();
    sleep_i <= 1'b1;
    tick(3);
    chk("wait_idle", {31'h0, wst}, 32'h0000_0001);
    sleep_i <= 1'b0;
    tick(3);
    wr(CSR_OFF, 8'h02);
    wr(ea(20), 8'h11);
    wr(CSR_OFF, 8'h03);
    sleep_i <= 1'b1;
    tick(3);
    chk("wait_busy", {31'h0, wst}, 32'h0000_0000);
    wait_done();
    tick(3);
    chk("wait_after", {31'h0, wst}, 32'h0000_0001);
    sleep_i <= 1'b0;
    tick(3);
    rd_chk("cell_wait", ea(20), 32'h0000_0011);
  endtask : t_wait

  // halt in mid cycle drops the flag at once; write mode stays
  task automatic t_halt();
    wr(CSR_OFF, 8'h02);
    wr(ea(21), 8'h22);
    wr(CSR_OFF, 8'h03);
    halt_i <= 1'b1;
    tick(2);
    chk("halted", {31'h0, hlt}, 32'h0000_0001);
    halt_i <= 1'b0;
    tick(2);
    rd_chk("halt_abort", CSR_OFF, 32'h0000_0002);
    wr(CSR_OFF, 8'h00);
    rd_chk("mode_off", CSR_OFF, 32'h0000_0000);
  endtask : t_halt

  always @(posedge clk_i) begin
    cycles++;
    // whole run needs a few hundred cycles at most
    if (cycles == 20000) begin
      mismatches++;
      stop_test();
    end
  end

  initial begin
    tick(16);
    reset_i <= 1'b0;
    tick(1);
    t_regs();
    t_prog();
    t_clear();
    t_wait();
    t_halt();
    stop_test();
  end
endmodule : ndw_ctrl_tb_top
